// ===== hdl/cs_pkg.sv
package cs_pkg;

   // register addresses (5-bit pointer space)
   localparam logic [4:0] ADDR_ENABLE = 5'h00;
   localparam logic [4:0] ADDR_ITIME = 5'h01;
   localparam logic [4:0] ADDR_WAIT_TIME = 5'h03;
   localparam logic [4:0] ADDR_LOW_TH_LO = 5'h04;
   localparam logic [4:0] ADDR_LOW_TH_HI = 5'h05;
   localparam logic [4:0] ADDR_HIGH_TH_LO = 5'h06;
   localparam logic [4:0] ADDR_HIGH_TH_HI = 5'h07;
   localparam logic [4:0] ADDR_FILTER = 5'h0c;
   localparam logic [4:0] ADDR_MISC = 5'h0d;
   localparam logic [4:0] ADDR_ANALOG = 5'h0f;
   localparam logic [4:0] ADDR_PART = 5'h12;
   localparam logic [4:0] ADDR_FLAGS = 5'h13;
   localparam logic [4:0] ADDR_CLR_LO = 5'h14;
   localparam logic [4:0] ADDR_CLR_HI = 5'h15;
   localparam logic [4:0] ADDR_RED_LO = 5'h16;
   localparam logic [4:0] ADDR_RED_HI = 5'h17;
   localparam logic [4:0] ADDR_GRN_LO = 5'h18;
   localparam logic [4:0] ADDR_GRN_HI = 5'h19;
   localparam logic [4:0] ADDR_BLU_LO = 5'h1a;
   localparam logic [4:0] ADDR_BLU_HI = 5'h1b;

   // reset values
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_ITIME = 8'hff;
   localparam logic [7:0] RST_WAIT_TIME = 8'hff;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [4:0] RST_PTR_ADDR = 5'h00;
   localparam logic [7:0] RST_RDATA = 8'h00;

   // pointer byte fields
   localparam int PTR_CMD_BIT = 7;
   localparam int PTR_KIND_HI = 6;
   localparam int PTR_KIND_LO = 5;
   localparam int PTR_FIELD_HI = 4;
   localparam logic [4:0] SF_IRQ_CLEAR = 5'h06;

   // enable and flag bit positions
   localparam int EN_IRQ_BIT = 4;
   localparam int EN_RGBC_BIT = 1;
   localparam int FLAG_IRQ_BIT = 4;
   localparam int FLAG_VALID_BIT = 0;

   // filter field, and the break point of its count table
   localparam int FILTER_W = 4;
   localparam logic [5:0] FILTER_LINEAR_MAX = 6'h03;
   localparam logic [5:0] FILTER_STEP = 6'h05;

   typedef enum logic [1:0] {
      CS_KIND_REPEAT = 2'b00,
      CS_KIND_AUTO = 2'b01,
      CS_KIND_RSVD = 2'b10,
      CS_KIND_SPECIAL = 2'b11
   } cs_kind_e;

   typedef struct packed {
      logic [15:0] clear;
      logic [15:0] red;
      logic [15:0] green;
      logic [15:0] blue;
   } cs_rgbc_s;

   typedef struct packed {
      logic [7:0] enable;
      logic [7:0] itime;
      logic [7:0] wait_time;
      logic [15:0] low_th;
      logic [15:0] high_th;
      logic [7:0] filter;
      logic [7:0] misc;
      logic [7:0] analog;
   } cs_setup_s;

endpackage

// ===== hdl/cs_ptr_decode.sv
`timescale 1ns/1ns
`default_nettype none
module cs_ptr_decode (
   input wire logic [7:0] i_byte,
   input wire logic i_first,
   output logic o_is_ptr,
   output cs_pkg::cs_kind_e o_kind,
   output logic [4:0] o_field,
   output logic o_irq_clear
);
   import cs_pkg::*;

   // a first byte without the marker bit is plain data at the stored address
   assign o_is_ptr = i_first & i_byte[PTR_CMD_BIT];
   assign o_kind = cs_kind_e'(i_byte[PTR_KIND_HI:PTR_KIND_LO]);
   assign o_field = i_byte[PTR_FIELD_HI:0];
   // other special codes are reserved and do nothing
   assign o_irq_clear = o_is_ptr && (o_kind == CS_KIND_SPECIAL) && (o_field == SF_IRQ_CLEAR);

endmodule // cs_ptr_decode
`default_nettype wire

// ===== hdl/cs_irq_eval.sv
`timescale 1ns/1ns
`default_nettype none
module cs_irq_eval (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_result_stb,
   input wire logic [15:0] i_clear,
   input wire logic [15:0] i_low_th,
   input wire logic [15:0] i_high_th,
   input wire logic [cs_pkg::FILTER_W-1:0] i_filter,
   input wire logic i_irq_clear,
   output logic o_pending
);
   import cs_pkg::*;

   logic out_of_range;
   logic [5:0] target;
   logic [5:0] run;
   logic [5:0] next_run;
   logic fire;

   // low limit is checked first; an inverted window ignores the high limit
   assign out_of_range = (i_clear < i_low_th) || ((i_low_th <= i_high_th) && (i_clear > i_high_th));

   // 0..3 count as is, higher codes step by five
   always_comb begin
      if ({2'b00, i_filter} <= FILTER_LINEAR_MAX) begin
         target = {2'b00, i_filter};
      end else begin
         target = 6'(({2'b00, i_filter} - FILTER_LINEAR_MAX) * FILTER_STEP);
      end
   end

   always_comb begin
      next_run = run;
      fire = 1'b0;
      if (i_result_stb) begin
         if (target == 6'h00) begin
            fire = 1'b1;
            next_run = 6'h00;
         end else if (out_of_range) begin
            next_run = (run == 6'h3f) ? run : 6'(run + 6'h01);
            fire = (next_run >= target);
         end else begin
            next_run = 6'h00;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         run <= 6'h00;
      end else if (i_ce) begin
         run <= next_run;
      end
   end

   // sticky until the clear command; a new event in the same cycle wins
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pending <= 1'b0;
      end else if (i_ce) begin
         if (fire) begin
            o_pending <= 1'b1;
         end else if (i_irq_clear) begin
            o_pending <= 1'b0;
         end
      end
   end

endmodule // cs_irq_eval
`default_nettype wire

// ===== hdl/cs_regs.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Pointer byte comes first; its selected register is the data target.
// - Pointer bits 6:5 pick repeated, auto-increment or special function.
// - Repeated mode keeps returning the same register, address unchanged.
// - Auto-increment mode steps the stored address after every data byte.
// - Bits 4:0 are register address, or special code in special mode.
// - Special code 00110 clears the pending interrupt, leaving no stored bit.
// - State and interrupt enable register at 0x00, read/write, resets 0x00.
// - Low threshold at 0x04/0x05, high at 0x06/0x07, read/write, reset zero.
// - Read-only results low byte first: clear, red, green, blue at 0x14-0x1b.
// - All registers reached only through the serial host byte port.
// - First byte after address in a write is the pointer when bit 7 is set; rest is data.
// - Reads without a new pointer use the retained register address.
// - Interrupt flag stays set until the clear special function arrives; the pin also needs enable bit 4.
module cs_regs #(
   parameter logic [7:0] PART_CODE = 8'h5a // arbitrary value
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_wr_stb,
   input wire logic i_wr_first,
   input wire logic [7:0] i_wdata,
   input wire logic i_rd_stb,
   input wire logic i_result_stb,
   input wire cs_pkg::cs_rgbc_s i_result,
   output logic [7:0] o_rdata,
   output cs_pkg::cs_setup_s o_setup,
   output logic o_irq
);
   import cs_pkg::*;

   // pointer state
   logic [4:0] ptr_addr;
   cs_kind_e ptr_kind;

   // host registers
   logic [7:0] enable;
   logic [7:0] itime;
   logic [7:0] wait_time;
   logic [15:0] low_th;
   logic [15:0] high_th;
   logic [7:0] filter;
   logic [7:0] misc;
   logic [7:0] analog;

   // results and flags
   cs_rgbc_s result;
   logic result_valid;
   logic pending;
   logic [7:0] flags;

   // decoded byte
   logic dec_is_ptr;
   cs_kind_e dec_kind;
   logic [4:0] dec_field;
   logic dec_irq_clear;
   logic data_wr;
   logic [7:0] next_rdata;
   logic [4:0] next_ptr_addr;

   cs_ptr_decode u_dec (
      .i_byte(i_wdata),
      .i_first(i_wr_first),
      .o_is_ptr(dec_is_ptr),
      .o_kind(dec_kind),
      .o_field(dec_field),
      .o_irq_clear(dec_irq_clear)
   );

   // every byte not taken as a pointer is register data
   assign data_wr = i_wr_stb & ~dec_is_ptr;

   // pointer register: address and transfer kind
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ptr_addr <= RST_PTR_ADDR;
         ptr_kind <= CS_KIND_REPEAT;
      end else if (i_ce) begin
         ptr_addr <= next_ptr_addr;
         if (i_wr_stb && dec_is_ptr && dec_kind != CS_KIND_RSVD && dec_kind != CS_KIND_SPECIAL) begin
            ptr_kind <= dec_kind;
         end
      end
   end

   // reserved kind and special codes keep the stored address for later reads
   always_comb begin
      next_ptr_addr = ptr_addr;
      if (i_wr_stb && dec_is_ptr) begin
         if (dec_kind == CS_KIND_REPEAT || dec_kind == CS_KIND_AUTO) begin
            next_ptr_addr = dec_field;
         end
      end else if ((data_wr || i_rd_stb) && ptr_kind == CS_KIND_AUTO) begin
         next_ptr_addr = 5'(ptr_addr + 5'h01);
      end
      // repeated kind leaves the address alone on data bytes
   end

   // writable registers; read-only addresses fall through untouched
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         enable <= RST_ENABLE;
         itime <= RST_ITIME;
         wait_time <= RST_WAIT_TIME;
         low_th <= {RST_BYTE, RST_BYTE};
         high_th <= {RST_BYTE, RST_BYTE};
         filter <= RST_BYTE;
         misc <= RST_BYTE;
         analog <= RST_BYTE;
      end else if (i_ce && data_wr) begin
         case (ptr_addr)
            ADDR_ENABLE: begin
               enable <= i_wdata;
            end
            ADDR_ITIME: begin
               itime <= i_wdata;
            end
            ADDR_WAIT_TIME: begin
               wait_time <= i_wdata;
            end
            ADDR_LOW_TH_LO: begin
               low_th[7:0] <= i_wdata;
            end
            ADDR_LOW_TH_HI: begin
               low_th[15:8] <= i_wdata;
            end
            ADDR_HIGH_TH_LO: begin
               high_th[7:0] <= i_wdata;
            end
            ADDR_HIGH_TH_HI: begin
               high_th[15:8] <= i_wdata;
            end
            ADDR_FILTER: begin
               filter <= i_wdata;
            end
            ADDR_MISC: begin
               misc <= i_wdata;
            end
            ADDR_ANALOG: begin
               analog <= i_wdata;
            end
            default: begin
               // part code, flags and results are not host-writable
            end
         endcase
      end
   end

   // results are captured whole on each strobe; a multi-byte read that spans a strobe mixes two cycles
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         result <= '0;
      end else if (i_ce && i_result_stb) begin
         result <= i_result;
      end
   end

   // valid flag follows the first result while conversions stay enabled
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         result_valid <= 1'b0;
      end else if (i_ce) begin
         if (i_result_stb) begin
            result_valid <= 1'b1;
         end else if (!enable[EN_RGBC_BIT]) begin
            result_valid <= 1'b0;
         end
      end
   end

   cs_irq_eval u_irq (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_ce(i_ce),
      .i_result_stb(i_result_stb),
      .i_clear(i_result.clear),
      .i_low_th(low_th),
      .i_high_th(high_th),
      .i_filter(filter[FILTER_W-1:0]),
      .i_irq_clear(i_wr_stb & dec_irq_clear),
      .o_pending(pending)
   );

   always_comb begin
      flags = 8'h00;
      flags[FLAG_IRQ_BIT] = pending;
      flags[FLAG_VALID_BIT] = result_valid;
   end

   // read mux uses the next address so the byte after a pointer or step is ready
   always_comb begin
      case (next_ptr_addr)
         ADDR_ENABLE: next_rdata = enable;
         ADDR_ITIME: next_rdata = itime;
         ADDR_WAIT_TIME: next_rdata = wait_time;
         ADDR_LOW_TH_LO: next_rdata = low_th[7:0];
         ADDR_LOW_TH_HI: next_rdata = low_th[15:8];
         ADDR_HIGH_TH_LO: next_rdata = high_th[7:0];
         ADDR_HIGH_TH_HI: next_rdata = high_th[15:8];
         ADDR_FILTER: next_rdata = filter;
         ADDR_MISC: next_rdata = misc;
         ADDR_ANALOG: next_rdata = analog;
         ADDR_PART: next_rdata = PART_CODE;
         ADDR_FLAGS: next_rdata = flags;
         ADDR_CLR_LO: next_rdata = result.clear[7:0];
         ADDR_CLR_HI: next_rdata = result.clear[15:8];
         ADDR_RED_LO: next_rdata = result.red[7:0];
         ADDR_RED_HI: next_rdata = result.red[15:8];
         ADDR_GRN_LO: next_rdata = result.green[7:0];
         ADDR_GRN_HI: next_rdata = result.green[15:8];
         ADDR_BLU_LO: next_rdata = result.blue[7:0];
         ADDR_BLU_HI: next_rdata = result.blue[15:8];
         default: next_rdata = 8'h00;
      endcase
   end

   // refreshed every enabled cycle; repeated mode re-reads the same register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= RST_RDATA;
      end else if (i_ce) begin
         o_rdata <= next_rdata;
      end
   end

   // pin shows the pending flag only while the enable bit allows it
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_irq <= 1'b0;
      end else if (i_ce) begin
         o_irq <= pending & enable[EN_IRQ_BIT];
      end
   end

   always_comb begin
      o_setup.enable = enable;
      o_setup.itime = itime;
      o_setup.wait_time = wait_time;
      o_setup.low_th = low_th;
      o_setup.high_th = high_th;
      o_setup.filter = filter;
      o_setup.misc = misc;
      o_setup.analog = analog;
   end

endmodule // cs_regs
`default_nettype wire

// ===== verif/cs_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module cs_regs_assertions (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_wr_stb,
   input wire logic i_wr_first,
   input wire logic [7:0] i_wdata,
   input wire logic i_rd_stb,
   input wire logic i_result_stb,
   input wire cs_pkg::cs_rgbc_s i_result,
   input wire logic [7:0] o_rdata,
   input wire cs_pkg::cs_setup_s o_setup,
   input wire logic o_irq
);
   import cs_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   logic wr_ok;
   logic data_wr;
   logic clr_hit;
   assign wr_ok = i_ce & i_wr_stb;
   assign data_wr = wr_ok & ~(i_wr_first & i_wdata[7]);
   assign clr_hit = wr_ok & i_wr_first & (i_wdata == 8'he6);

   a_reset_values: assert property ($rose(i_nrst) |-> o_setup.itime == 8'hff && o_setup.wait_time == 8'hff
      && o_setup.enable == 8'h00 && o_rdata == 8'h00 && !o_irq) else $error("reset values wrong");
   a_ptr_target: assert property (wr_ok && i_wr_first && i_wdata == 8'h80 |=> o_rdata == o_setup.enable)
      else $error("pointer did not select register");
   a_auto_write: assert property ((wr_ok && i_wr_first && i_wdata == 8'ha4) ##1 data_wr ##1 data_wr
      |=> o_setup.low_th == {$past(i_wdata), $past(i_wdata, 2)}) else $error("auto write wrong");
   a_repeat_write: assert property ((wr_ok && i_wr_first && i_wdata == 8'h8f) ##1 data_wr [*2]
      |=> o_setup.analog == $past(i_wdata)) else $error("repeated write wrong");
   a_auto_read: assert property ((wr_ok && i_wr_first && i_wdata == 8'ha6) ##1 (i_ce && i_rd_stb && !i_wr_stb)
      |=> o_rdata == o_setup.high_th[15:8]) else $error("auto read wrong");
   a_ro_ignore: assert property ((wr_ok && i_wr_first && i_wdata == 8'h92) ##1 data_wr
      |=> ##1 o_rdata == $past(o_rdata, 2)) else $error("read-only byte changed");
   a_irq_clear: assert property ((clr_hit && !i_result_stb) ##1 (i_ce && !i_result_stb) |=> !o_irq)
      else $error("interrupt not cleared");
   a_irq_hold: assert property (o_irq && o_setup.enable[4] && !$past(clr_hit) |=> o_irq)
      else $error("interrupt dropped early");
   a_irq_gate: assert property (o_irq && $past(i_ce) |-> $past(o_setup.enable[4]))
      else $error("interrupt not masked");
endmodule // cs_regs_assertions

bind cs_regs cs_regs_assertions u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_wr_stb(i_wr_stb),
   .i_wr_first(i_wr_first), .i_wdata(i_wdata), .i_rd_stb(i_rd_stb), .i_result_stb(i_result_stb),
   .i_result(i_result), .o_rdata(o_rdata), .o_setup(o_setup), .o_irq(o_irq));
`default_nettype wire

// ===== verif/cs_host.sv
`timescale 1ns/1ns
`default_nettype none
// host side of the byte port; calls come just after a falling edge
module cs_host (
   output logic o_wr_stb,
   output logic o_wr_first,
   output logic [7:0] o_wdata,
   output logic o_rd_stb
);
   initial begin
      o_wr_stb = 1'b0;
      o_wr_first = 1'b0;
      o_wdata = 8'h00;
      o_rd_stb = 1'b0;
   end
   task automatic send(input logic first, input logic [7:0] b);
      o_wr_stb = 1'b1;
      o_rd_stb = 1'b0;
      o_wr_first = first;
      o_wdata = b;
   endtask
   // released data toggles so a stale byte never matches by luck
   task automatic take();
      o_wr_stb = 1'b0;
      o_rd_stb = 1'b1;
      o_wdata = ~o_wdata;
   endtask
   task automatic idle();
      o_wr_stb = 1'b0;
      o_rd_stb = 1'b0;
      o_wr_first = ~o_wr_first;
      o_wdata = ~o_wdata;
   endtask
endmodule // cs_host
`default_nettype wire

// ===== verif/cs_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
module cs_regs_test;
   import cs_pkg::*;
   logic clk, nrst, ce, res_stb, wr_stb, wr_first, rd_stb, irq;
   logic [7:0] wdata, rdata;
   cs_rgbc_s res;
   logic [7:0] m [0:31];
   // only legal pointers: kind 10 and spare special codes are never sent
   logic [7:0] seq_w [6] = '{8'h8f, 8'ha4, 8'h92, 8'h87, 8'hb6, 8'h8d};
   int fail_count, cmp_count, ma, mk, cnt, pend, valid, irq_a, skip, rnd, i;

   cs_regs #(.PART_CODE(8'h3c)) u_dut ( // arbitrary part code
      .i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_wr_stb(wr_stb), .i_wr_first(wr_first), .i_wdata(wdata),
      .i_rd_stb(rd_stb), .i_result_stb(res_stb), .i_result(res), .o_rdata(rdata), .o_setup(), .o_irq(irq));
   cs_host u_host (.o_wr_stb(wr_stb), .o_wr_first(wr_first), .o_wdata(wdata), .o_rd_stb(rd_stb));

   always #25 clk = ~clk;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (fail_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic init_model();
      foreach (m[k]) m[k] = 8'h00;
      m[1] = 8'hff;
      m[3] = 8'hff;
      m[18] = 8'h3c;
      {ma, mk, cnt, pend, valid, irq_a, skip} = '0;
   endtask

   // read byte may lag one cycle after a store, so those cycles are not compared
   task automatic step();
      @(negedge clk);
      if (skip == 0) chk(rdata, m[ma]);
      chk({7'h00, irq}, 8'(irq_a));
      ce = (rnd == 0) || ($urandom % 4 != 0);
      if (ce) begin
         skip = 0;
         irq_a = pend & m[0][4];
      end
   endtask

   task automatic wr(input logic first, input logic [7:0] b);
      step();
      res_stb = 1'b0;
      u_host.send(first, b);
      if (ce && first && b[7]) begin
         if (!b[6]) begin
            ma = b[4:0];
            mk = b[5];
         end else if (b[5] && b[4:0] == SF_IRQ_CLEAR) begin
            pend = 0;
            skip = 1;
         end
      end else if (ce) begin
         if (ma inside {0, 1, 3, [4:7], 12, 13, 15}) m[ma] = b;
         if (mk == 1) ma = (ma + 1) % 32;
         skip = 1;
      end
      m[19] = 8'(pend * 16 + valid);
   endtask

   task automatic rd();
      step();
      res_stb = 1'b0;
      u_host.take();
      if (ce && mk == 1) ma = (ma + 1) % 32;
   endtask

   task automatic result(input logic [15:0] c);
      logic [15:0] lo, hi;
      int need;
      step();
      u_host.idle();
      res_stb = 1'b1;
      res = {c, 16'($urandom), 16'($urandom), 16'($urandom)};
      if (ce) begin
         lo = {m[5], m[4]};
         hi = {m[7], m[6]};
         need = (m[12][3:0] <= 3) ? m[12][3:0] : (m[12][3:0] - 3) * 5;
         // filter 0 fires on every result and keeps no run count
         if (need == 0) cnt = 0;
         else if (c < lo || (lo <= hi && c > hi)) cnt = (cnt < 63) ? cnt + 1 : 63;
         else cnt = 0;
         if (need == 0 || (cnt > 0 && cnt >= need)) pend = 1;
         for (int k = 0; k < 8; k++) m[20 + k] = res[48 - 16 * (k / 2) + 8 * (k % 2) +: 8];
         valid = 1;
         skip = 1;
      end
      m[19] = 8'(pend * 16 + valid);
   endtask

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      ce = 1'b1;
      res_stb = 1'b0;
      res = '0;
      {fail_count, cmp_count, rnd} = '0;
      i = $urandom(29);
      init_model();
      repeat (10) @(posedge clk);
      @(negedge clk) nrst = 1'b1;
      for (int pass = 0; pass < 2; pass++) begin
         // whole map once over the top, wrap to 0x00 included
         wr(1'b1, 8'ha0);
         repeat (33) rd();
         wr(1'b1, 8'h80);
         wr(1'b0, 8'h13);
         wr(1'b1, 8'ha1);
         repeat (15) wr(1'b0, 8'($urandom));
         wr(1'b1, 8'ha0);
         repeat (16) rd();
         foreach (seq_w[k]) begin
            wr(1'b1, seq_w[k]);
            wr(1'b0, 8'($urandom));
            wr(1'b0, 8'($urandom));
            rd();
         end
         wr(1'b1, 8'h2a);
         wr(1'b1, 8'ha6);
         rd();
         wr(1'b1, 8'ha4);
         foreach (seq_w[k]) if (k < 4) wr(1'b0, 8'(k % 2 + k / 2 * 2));
         for (i = 0; i < 6; i++) begin
            wr(1'b1, 8'h8c);
            wr(1'b0, 8'(i));
            wr(1'b1, 8'h93);
            repeat (12) begin
               result(i > 3 ? 16'h0010 : 16'($urandom % 768));
               rd();
            end
            if (i == 2) begin
               wr(1'b1, 8'h80);
               wr(1'b0, 8'h03);
               result(16'h0010);
               wr(1'b0, 8'h13);
               rd();
            end
            wr(1'b1, 8'he6);
            rd();
            rd();
         end
         wr(1'b1, 8'h8d);
         rnd = 1;
         repeat (60) case ($urandom % 3)
            0: rd();
            1: result(16'($urandom % 768));
            default: wr(1'b0, 8'($urandom));
         endcase
         rnd = 0;
         if (pass == 0) begin
            @(negedge clk);
            nrst = 1'b0;
            res_stb = 1'b0;
            u_host.idle();
            init_model();
            repeat (3) @(negedge clk);
            nrst = 1'b1;
         end
      end
      stop_test();
   end
endmodule // cs_regs_test
`default_nettype wire
